// ==== hw/ptbi_cfg.svh ====
`ifndef PTBI_CFG_SVH
`define PTBI_CFG_SVH
// Summary of operation
// - charging-header low-pressure trip bypassed only in shutdown/refuel, after scram, all four switches set
// - annunciate while the charging-header low-pressure bypass is in effect
// - startup or run mode cancels the charging-header bypass whatever the switches say
// - separate alarm when any charging bypass switch is set in startup or run
// - rod-withdrawal inhibit whenever any charging bypass switch is set, any mode
// - isolation-valve closure trip bypassed and annunciated outside run mode
// - shutdown-position mode trip bypassed automatically about ten seconds after it starts
// - run mode bypasses every startup-range monitor scram trip and annunciates it on srm_byp
// - run mode disables the startup-range monitor rod-block outputs
// - run mode drops non-coincident flux trips where selected; those systems stay coincident
// - abnormal alarm in run mode when any coincidence switch is non-coincident
// - maintenance bypasses never mask a trip function, only reduce redundancy
// - status alarm whenever any maintenance bypass is in effect
// - one sensor-division bypass input per division, at most one granted at once
// - annunciate sensor-division bypass and show which division it is
// - four out-of-service bypass inputs, only one trip logic unit bypassed at once
// - annunciate out-of-service bypass and show which division is out
// - manual trip of an out-of-service division still trips that division
// - sensor and out-of-service bypasses are granted independently of each other
// - selector decodes to shutdown, refuel, startup and run driving all mode logic
// - shutdown position of the selector initiates a scram trip
// - two manual scram inputs, one per actuator power division, acting independently
// - trips latch until manual reset; division trip resets ignored about ten seconds after trip, manual latches reset at once

// ==========================================================================
// timing
`define PTBI_CLK_HZ        64'd250_000_000
`define PTBI_DELAY_S       64'd10
`define PTBI_DELAY_CYC     (32'(`PTBI_CLK_HZ * `PTBI_DELAY_S))
// ==========================================================================
// mode selector encoding (gray along shutdown-refuel-startup-run)
`define PTBI_MODE_SD       2'h0
`define PTBI_MODE_RF       2'h1
`define PTBI_MODE_SU       2'h3
`define PTBI_MODE_RUN      2'h2
// ==========================================================================
// register offsets (byte addresses)
`define PTBI_STATUS_OFS    12'h000
`define PTBI_TRIP_OFS      12'h004
`define PTBI_BYPASS_OFS    12'h008
`define PTBI_CTRL_OFS      12'h00c
// field positions
`define PTBI_CTRL_MAN_RST  4
`define PTBI_BYP_OOS_LSB   4
`define PTBI_STAT_FSM_LSB  2
`define PTBI_STAT_ALM_LSB  4
`define PTBI_TRIP_MAN_LSB  4
`define PTBI_TRIP_SEEN     6
`define PTBI_TRIP_MDIV_LSB 8
`endif

// ==== hw/ptbi_pkg.sv ====
`include "ptbi_cfg.svh"
package ptbi_pkg;
   typedef enum logic [1:0] {
      PTBI_MODE_SHUTDOWN = `PTBI_MODE_SD,
      PTBI_MODE_REFUEL   = `PTBI_MODE_RF,
      PTBI_MODE_STARTUP  = `PTBI_MODE_SU,
      PTBI_MODE_RUN      = `PTBI_MODE_RUN
   } ptbi_mode_t;

   // shutdown mode-trip sequencer
   typedef enum logic [1:0] {
      PTBI_SD_IDLE     = 2'h0,
      PTBI_SD_TIMING   = 2'h1,
      PTBI_SD_BYPASSED = 2'h3
   } ptbi_sd_state_t;

   typedef struct packed {
      ptbi_sd_state_t   sd_state;
      logic [31:0]      sd_tmr;
      logic [3:0]       div_latch;
      logic [3:0]       man_div_latch;
      logic [3:0][31:0] div_tmr;
      logic [1:0]       man_latch;
      logic             scram_seen;
      logic [3:0]       sens_grant;
      logic [3:0]       oos_grant;
      logic [31:0]      prdata;
      logic             slverr;
      logic [3:0]       div_trip_out;
      logic [1:0]       man_trip_out;
      logic             chg_byp_annc;
      logic             chg_alarm;
      logic             rod_inhibit;
      logic             isolation_valve_byp;
      logic             srm_byp;
      logic [3:0]       srm_block_out;
      logic [3:0]       nc_disable;
      logic             nc_alarm_run;
      logic             nc_alarm_stop;
      logic             maint_alarm;
   } ptbi_state_t;
endpackage : ptbi_pkg

// ==== hw/ptbi_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for a group of switch inputs
module ptbi_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // raw and synchronised levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_reg;

   // ==========================================================================
   // first flop feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         dout     <= '0;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule : ptbi_sync

// ==== hw/ptbi_top.sv ====
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "ptbi_cfg.svh"
module ptbi_top #(
   parameter logic [31:0] TRIP_DELAY_CYC = `PTBI_DELAY_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // operator switches (asynchronous pins)
   input  wire logic [1:0]  mode_sel,
   input  wire logic [3:0]  chg_byp_sw,
   input  wire logic [3:0]  sens_byp_sw,
   input  wire logic [3:0]  oos_byp_sw,
   input  wire logic [3:0]  nc_sel_sw,
   input  wire logic [1:0]  man_scram_sw,
   input  wire logic [3:0]  man_div_sw,
   // per trip system conditions from voting logic (same clock)
   input  wire logic [3:0]  chg_low_trip,
   input  wire logic [3:0]  isolation_valve_trip,
   input  wire logic [3:0]  startup_range_monitor_trip,
   input  wire logic [3:0]  flux_monitor_nc_trip,
   input  wire logic [3:0]  other_trip,
   input  wire logic [3:0]  srm_rod_block_in,
   // trip and bypass outputs
   output logic      [3:0]  div_trip_out,
   output logic      [1:0]  man_trip_out,
   output logic      [3:0]  sens_byp_div,
   output logic      [3:0]  oos_byp_div,
   output logic      [3:0]  srm_block_out,
   output logic      [3:0]  nc_disable,
   // annunciation and alarms
   output logic             chg_byp_annc,
   output logic             chg_alarm,
   output logic             rod_inhibit,
   output logic             isolation_valve_byp,
   output logic             srm_byp,
   output logic             nc_alarm_run,
   output logic             nc_alarm_stop,
   output logic             maint_alarm,
   output logic             sens_byp_annc,
   output logic             oos_byp_annc
);
   import ptbi_pkg::*;

   ptbi_state_t st_reg;
   ptbi_state_t st_next;
   logic [23:0] sw_s;
   logic [1:0]  mode_s;
   logic [3:0]  chg_sw_s;
   logic [3:0]  sens_sw_s;
   logic [3:0]  oos_sw_s;
   logic [3:0]  nc_sw_s;
   logic [1:0]  man_sw_s;
   logic [3:0]  man_div_s;

   // ==========================================================================
   // input synchronisation; the selector travels inverted so a cleared
   // synchroniser reads as startup, not shutdown, and reset release gives no false trip
   ptbi_sync #(.W(24)) ptbi_sync_i (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({man_div_sw, man_scram_sw, nc_sel_sw, oos_byp_sw, sens_byp_sw, chg_byp_sw, ~mode_sel}),
      .dout    (sw_s)
   );
   assign mode_s    = ~sw_s[1:0];
   assign chg_sw_s  = sw_s[5:2];
   assign sens_sw_s = sw_s[9:6];
   assign oos_sw_s  = sw_s[13:10];
   assign nc_sw_s   = sw_s[17:14];
   assign man_sw_s  = sw_s[19:18];
   assign man_div_s = sw_s[23:20];

   // ==========================================================================
   // one-division interlock: a held grant stays, else the lowest request wins
   function automatic logic [3:0] ptbi_pick_one(input logic [3:0] cur, input logic [3:0] req);
      logic [3:0] res;
      res = 4'h0;
      if (|(cur & req)) begin
         res = cur;
      end else begin
         for (int i = 3; i >= 0; i--) begin
            if (req[i]) begin
               res = 4'h0;
               res[i] = 1'b1;
            end
         end
      end
      return res;
   endfunction : ptbi_pick_one

   // ==========================================================================
   // next-state logic
   always_comb begin
      ptbi_mode_t mode;
      logic       is_sd;
      logic       is_rf;
      logic       is_run;
      logic       sd_trip;
      logic       chg_byp;
      logic [3:0] raw;
      logic [3:0] rst_div;
      logic       rst_man;
      logic       wr_ctrl;
      logic [2:0] ndiv;
      mode    = ptbi_mode_t'(mode_s);
      is_sd   = (mode == PTBI_MODE_SHUTDOWN);
      is_rf   = (mode == PTBI_MODE_REFUEL);
      is_run  = (mode == PTBI_MODE_RUN);
      st_next = st_reg;
      ndiv    = 3'h0;

      // apb write to the control register pulses the reset requests
      wr_ctrl = psel && penable && pwrite && (paddr == `PTBI_CTRL_OFS);
      rst_div = wr_ctrl ? pwdata[3:0] : 4'h0;
      rst_man = wr_ctrl && pwdata[`PTBI_CTRL_MAN_RST];

      // shutdown mode trip, self-bypassed after the delay
      case (st_reg.sd_state)
         PTBI_SD_IDLE: begin
            st_next.sd_tmr = 32'h0;
            if (is_sd) begin
               st_next.sd_state = PTBI_SD_TIMING;
            end
         end
         PTBI_SD_TIMING: begin
            st_next.sd_tmr = st_reg.sd_tmr + 32'h1;
            if (!is_sd) begin
               st_next.sd_state = PTBI_SD_IDLE;
            end else if (st_reg.sd_tmr >= TRIP_DELAY_CYC - 32'h1) begin
               st_next.sd_state = PTBI_SD_BYPASSED;
            end
         end
         PTBI_SD_BYPASSED: begin
            if (!is_sd) begin
               st_next.sd_state = PTBI_SD_IDLE;
            end
         end
         default: begin
            st_next.sd_state = PTBI_SD_IDLE;
         end
      endcase
      sd_trip = is_sd && (st_reg.sd_state != PTBI_SD_BYPASSED);

      // operational bypasses; mode test also cancels it in startup/run
      chg_byp = (is_sd || is_rf) && st_reg.scram_seen && (&chg_sw_s);
      st_next.isolation_valve_byp = !is_run;
      st_next.srm_byp             = is_run;
      st_next.nc_disable          = is_run ? nc_sw_s : 4'h0;

      // raw per-system trip: maintenance bypasses never enter here
      raw = (chg_low_trip & {4{!chg_byp}})
          | (isolation_valve_trip & {4{is_run}})
          | (startup_range_monitor_trip & {4{!is_run}})
          | (flux_monitor_nc_trip & nc_sw_s & {4{!is_run}})
          | other_trip
          | {4{sd_trip}};

      // seal-in with reset lockout; a new trip beats a reset
      for (int d = 0; d < 4; d++) begin
         if (raw[d] && !st_reg.div_latch[d]) begin
            st_next.div_latch[d] = 1'b1;
            st_next.div_tmr[d]   = 32'h0;
         end else if (st_reg.div_latch[d]) begin
            if (st_reg.div_tmr[d] < TRIP_DELAY_CYC) begin
               st_next.div_tmr[d] = st_reg.div_tmr[d] + 32'h1;
            end
            if (rst_div[d] && !raw[d] && (st_reg.div_tmr[d] >= TRIP_DELAY_CYC)) begin
               st_next.div_latch[d] = 1'b0;
            end
         end
         if (man_div_s[d]) begin
            st_next.man_div_latch[d] = 1'b1;
         end else if (rst_div[d]) begin
            st_next.man_div_latch[d] = 1'b0;
         end
      end

      // manual scram systems, each on its own actuator power division
      for (int m = 0; m < 2; m++) begin
         if (man_sw_s[m] || sd_trip) begin
            st_next.man_latch[m] = 1'b1;
         end else if (rst_man) begin
            st_next.man_latch[m] = 1'b0;
         end
      end

      // maintenance bypass grants, judged independently
      st_next.sens_grant = ptbi_pick_one(st_reg.sens_grant, sens_sw_s);
      st_next.oos_grant  = ptbi_pick_one(st_reg.oos_grant, oos_sw_s);

      // outputs registered from the next state, so they line up with it
      st_next.div_trip_out = (st_next.div_latch & ~st_next.oos_grant) | st_next.man_div_latch;
      st_next.man_trip_out = st_next.man_latch;
      for (int d = 0; d < 4; d++) begin
         ndiv = ndiv + {2'h0, st_next.div_trip_out[d]};
      end

      // scram seen stays until every trip system is reset
      if ((ndiv >= 3'h2) || (&st_next.man_latch)) begin
         st_next.scram_seen = 1'b1;
      end else if (st_next.div_trip_out == 4'h0 && st_next.man_latch == 2'h0) begin
         st_next.scram_seen = 1'b0;
      end

      st_next.chg_byp_annc  = chg_byp;
      st_next.chg_alarm     = (|chg_sw_s) && !is_sd && !is_rf;
      st_next.rod_inhibit   = |chg_sw_s;
      st_next.srm_block_out = srm_rod_block_in & {4{!is_run}};
      st_next.nc_alarm_run  = is_run && (|nc_sw_s);
      st_next.nc_alarm_stop = !is_run && (|nc_sw_s);
      st_next.maint_alarm   = (|st_next.sens_grant) || (|st_next.oos_grant);

      // apb read data and error captured in the setup phase
      if (psel && !penable) begin
         st_next.prdata = 32'h0;
         st_next.slverr = 1'b0;
         if (paddr == `PTBI_STATUS_OFS) begin
            st_next.prdata[1:0] = mode_s;
            st_next.prdata[`PTBI_STAT_FSM_LSB +: 2] = st_reg.sd_state;
            st_next.prdata[`PTBI_STAT_ALM_LSB +: 9] = {st_reg.maint_alarm, st_reg.nc_alarm_stop,
               st_reg.nc_alarm_run, st_reg.srm_byp, st_reg.isolation_valve_byp, st_reg.rod_inhibit,
               st_reg.chg_alarm, st_reg.chg_byp_annc, sd_trip};
         end else if (paddr == `PTBI_TRIP_OFS) begin
            st_next.prdata[3:0] = st_reg.div_latch;
            st_next.prdata[`PTBI_TRIP_MAN_LSB +: 2] = st_reg.man_latch;
            st_next.prdata[`PTBI_TRIP_SEEN] = st_reg.scram_seen;
            st_next.prdata[`PTBI_TRIP_MDIV_LSB +: 4] = st_reg.man_div_latch;
         end else if (paddr == `PTBI_BYPASS_OFS) begin
            st_next.prdata[3:0] = st_reg.sens_grant;
            st_next.prdata[`PTBI_BYP_OOS_LSB +: 4] = st_reg.oos_grant;
         end else if (paddr == `PTBI_CTRL_OFS) begin
            st_next.prdata = 32'h0; // write-only pulses read as zero
         end else begin
            st_next.slverr = 1'b1;
         end
      end
   end

   // ==========================================================================
   // state register; trip latches come up clear, outside-run bypass comes up off too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================================
   // output assignments
   assign prdata              = st_reg.prdata;
   assign pready              = 1'b1; // zero-wait slave
   assign pslverr             = st_reg.slverr && psel && penable;
   assign div_trip_out        = st_reg.div_trip_out;
   assign man_trip_out        = st_reg.man_trip_out;
   assign sens_byp_div        = st_reg.sens_grant;
   assign oos_byp_div         = st_reg.oos_grant;
   assign sens_byp_annc       = |st_reg.sens_grant;
   assign oos_byp_annc        = |st_reg.oos_grant;
   assign srm_block_out       = st_reg.srm_block_out;
   assign nc_disable          = st_reg.nc_disable;
   assign chg_byp_annc        = st_reg.chg_byp_annc;
   assign chg_alarm           = st_reg.chg_alarm;
   assign rod_inhibit         = st_reg.rod_inhibit;
   assign isolation_valve_byp = st_reg.isolation_valve_byp;
   assign srm_byp             = st_reg.srm_byp;
   assign nc_alarm_run        = st_reg.nc_alarm_run;
   assign nc_alarm_stop       = st_reg.nc_alarm_stop;
   assign maint_alarm         = st_reg.maint_alarm;

   // ==========================================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_chg_byp_cancel: assert property ((mode_s == `PTBI_MODE_SU || mode_s == `PTBI_MODE_RUN)
      |=> !chg_byp_annc) else $error("charging bypass held in startup or run");
   a_chg_byp_cause: assert property (chg_byp_annc |-> $past(&chg_sw_s) && $past(st_reg.scram_seen))
      else $error("charging bypass without all switches and scram");
   a_chg_alarm_set: assert property (((|chg_sw_s) && mode_s[1]) |=> chg_alarm)
      else $error("charging switch alarm missing");
   a_rod_inhibit_set: assert property ((|chg_sw_s) |=> rod_inhibit)
      else $error("rod inhibit missing");
   a_valve_byp_mode: assert property ((mode_s != `PTBI_MODE_RUN) |=> isolation_valve_byp)
      else $error("isolation valve bypass missing outside run");
   a_srm_run_off: assert property ((mode_s == `PTBI_MODE_RUN) |=> srm_byp && srm_block_out == 4'h0)
      else $error("startup range functions active in run");
   a_nc_alarm_run: assert property (((mode_s == `PTBI_MODE_RUN) && (|nc_sw_s)) |=> nc_alarm_run)
      else $error("non-coincident alarm missing in run");
   a_sens_one_div: assert property ($onehot0(sens_byp_div))
      else $error("more than one sensor division bypassed");
   a_oos_one_div: assert property ($onehot0(oos_byp_div))
      else $error("more than one division out of service");
   a_trip_seal_in: assert property ($rose(st_reg.div_latch[0]) |=> st_reg.div_latch[0] [*8])
      else $error("trip released inside lockout");
   a_manual_div_trip: assert property (st_reg.man_div_latch[0] |-> div_trip_out[0])
      else $error("manual trip lost in out-of-service division");
   a_sd_mode_trip: assert property (((mode_s == `PTBI_MODE_SD) && st_reg.sd_state == PTBI_SD_IDLE)
      |=> st_reg.div_latch == 4'hf && man_trip_out == 2'h3) else $error("shutdown mode trip missing");
   a_manual_scram: assert property (man_sw_s[1] |=> man_trip_out[1])
      else $error("manual scram not latched");
endmodule : ptbi_top

// ==== bench/ptbi_panel.sv ====
`timescale 1ns/1ps
// ==========================================================
// operator panel: keylock switches and the mode selector
module ptbi_panel (
   // clock
   input  wire logic       pclk,
   // keylock and selector pins
   output logic      [1:0] mode_sel,
   output logic      [3:0] chg_byp_sw,
   output logic      [3:0] sens_byp_sw,
   output logic      [3:0] oos_byp_sw,
   output logic      [3:0] nc_sel_sw,
   output logic      [1:0] man_scram_sw,
   output logic      [3:0] man_div_sw
);
   // panel powers up in run with every key released
   initial begin
      {mode_sel, chg_byp_sw, sens_byp_sw, oos_byp_sw, nc_sel_sw, man_scram_sw, man_div_sw} = {2'h2, 22'h0};
   end

   // keys move just after an edge and stay put until the next call
   task put(input logic [1:0] m, input logic [3:0] c, s, o, n, input logic [1:0] ms, input logic [3:0] md);
      @(posedge pclk);
      mode_sel     <= m;
      chg_byp_sw   <= c;
      sens_byp_sw  <= s;
      oos_byp_sw   <= o;
      nc_sel_sw    <= n;
      man_scram_sw <= ms;
      man_div_sw   <= md;
   endtask : put
endmodule : ptbi_panel

// ==== bench/ptbi_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================
// bench top: apb master, trip inputs and scenarios
module ptbi_tb_top;
   import ptbi_pkg::*;
   localparam logic [1:0] SD = PTBI_MODE_SHUTDOWN, RF = PTBI_MODE_REFUEL;
   localparam logic [1:0] SU = PTBI_MODE_STARTUP, RN = PTBI_MODE_RUN;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [1:0] mode_sel, man_scram_sw, man_trip_out;
   logic [3:0] chg_byp_sw, sens_byp_sw, oos_byp_sw, nc_sel_sw, man_div_sw;
   logic [3:0] chg_low_trip, isolation_valve_trip, startup_range_monitor_trip;
   logic [3:0] flux_monitor_nc_trip, other_trip, srm_rod_block_in;
   logic [3:0] div_trip_out, sens_byp_div, oos_byp_div, srm_block_out, nc_disable;
   logic chg_byp_annc, chg_alarm, rod_inhibit, isolation_valve_byp, srm_byp, e;
   logic nc_alarm_run, nc_alarm_stop, maint_alarm, sens_byp_annc, oos_byp_annc;
   int fail_count = 0, n_compared = 0, cyc = 0;

   // short trip delay keeps the seal-in window visible in a short run
   ptbi_top #(.TRIP_DELAY_CYC(32'd20)) ptbi_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_sel, .chg_byp_sw, .sens_byp_sw,
      .oos_byp_sw, .nc_sel_sw, .man_scram_sw, .man_div_sw, .chg_low_trip, .isolation_valve_trip,
      .startup_range_monitor_trip, .flux_monitor_nc_trip, .other_trip, .srm_rod_block_in,
      .div_trip_out, .man_trip_out, .sens_byp_div, .oos_byp_div, .srm_block_out, .nc_disable,
      .chg_byp_annc, .chg_alarm, .rod_inhibit, .isolation_valve_byp, .srm_byp, .nc_alarm_run,
      .nc_alarm_stop, .maint_alarm, .sens_byp_annc, .oos_byp_annc);
   ptbi_panel ptbi_panel_i (.pclk, .mode_sel, .chg_byp_sw, .sens_byp_sw, .oos_byp_sw,
      .nc_sel_sw, .man_scram_sw, .man_div_sw);

   // ==========================================================
   // clock, reset and hang guard
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         results();
      end
   end

   // ==========================================================
   // helpers
   task go(input int n);
      repeat (n) @(posedge pclk);
   endtask : go
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rchk(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("prdata", x, d);
   endtask : rchk
   // switch change, then three synchroniser/output edges plus margin
   task sw(input logic [1:0] m, input logic [3:0] c, s, o, n, input logic [1:0] ms, input logic [3:0] md);
      ptbi_panel_i.put(m, c, s, o, n, ms, md);
      go(4);
   endtask : sw
   // clear waits out the reset lockout before writing every reset bit
   task clr;
      go(30);
      apb(1'b1, 12'h00c, 32'h1f);
      go(2);
      chk("div_trip_out", 0, div_trip_out);
      chk("man_trip_out", 0, man_trip_out);
   endtask : clr

   // ==========================================================
   // scenarios
   task t_regs;
      rchk(12'h000, 32'h202);
      rchk(12'h004, 32'h0);
      rchk(12'h008, 32'h0);
      rchk(12'h00c, 32'h0);
      apb(1'b1, 12'h000, 32'hffffffff);
      rchk(12'h000, 32'h202);
      apb(1'b0, 12'h010, 32'h0);
      chk("pslverr", 1, e);
      chk("prdata", 0, d);
   endtask : t_regs
   task t_chg;
      sw(RN, 4'hf, 0, 0, 0, 0, 0);
      chk("chg_alarm", 1, chg_alarm);
      chk("rod_inhibit", 1, rod_inhibit);
      chk("chg_byp_annc", 0, chg_byp_annc);
      sw(RF, 4'h7, 0, 0, 0, 2'h3, 0);
      chk("man_trip_out", 3, man_trip_out);
      chk("chg_byp_annc", 0, chg_byp_annc);
      chk("rod_inhibit", 1, rod_inhibit);
      chk("chg_alarm", 0, chg_alarm);
      sw(RF, 4'hf, 0, 0, 0, 0, 0);
      chk("chg_byp_annc", 1, chg_byp_annc);
      @(posedge pclk) chg_low_trip <= 4'hf;
      go(2);
      chk("div_trip_out", 0, div_trip_out);
      sw(SU, 4'hf, 0, 0, 0, 0, 0);
      go(2);
      chk("chg_byp_annc", 0, chg_byp_annc);
      chk("div_trip_out", 4'hf, div_trip_out);
      chk("chg_alarm", 1, chg_alarm);
      chk("isolation_valve_byp", 1, isolation_valve_byp);
      @(posedge pclk) chg_low_trip <= 4'h0;
      sw(RN, 0, 0, 0, 0, 0, 0);
      clr();
   endtask : t_chg
   task t_iso;
      chk("isolation_valve_byp", 0, isolation_valve_byp);
      @(posedge pclk) isolation_valve_trip <= 4'h1;
      go(2);
      chk("div_trip_out", 4'h1, div_trip_out);
      @(posedge pclk) isolation_valve_trip <= 4'h0;
      apb(1'b1, 12'h00c, 32'h1f);
      go(2);
      chk("div_trip_out", 4'h1, div_trip_out);
      clr();
   endtask : t_iso
   task t_srm;
      @(posedge pclk) startup_range_monitor_trip <= 4'hf;
      srm_rod_block_in <= 4'hf;
      flux_monitor_nc_trip <= 4'hf;
      sw(RN, 0, 0, 0, 4'h5, 0, 0);
      chk("srm_byp", 1, srm_byp);
      chk("maint_alarm", 0, maint_alarm);
      chk("srm_block_out", 0, srm_block_out);
      chk("nc_disable", 4'h5, nc_disable);
      chk("div_trip_out", 0, div_trip_out);
      chk("nc_alarm_run", 1, nc_alarm_run);
      chk("nc_alarm_stop", 0, nc_alarm_stop);
      @(posedge pclk) startup_range_monitor_trip <= 4'h0;
      flux_monitor_nc_trip <= 4'h0;
      sw(RF, 0, 0, 0, 4'h5, 0, 0);
      chk("srm_byp", 0, srm_byp);
      chk("srm_block_out", 4'hf, srm_block_out);
      chk("nc_alarm_run", 0, nc_alarm_run);
      chk("nc_alarm_stop", 1, nc_alarm_stop);
      @(posedge pclk) flux_monitor_nc_trip <= 4'hf;
      go(2);
      chk("div_trip_out", 4'h5, div_trip_out);
      @(posedge pclk) flux_monitor_nc_trip <= 4'h0;
      srm_rod_block_in <= 4'h0;
      sw(RN, 0, 0, 0, 0, 0, 0);
      clr();
   endtask : t_srm
   task t_maint;
      sw(RN, 0, 4'h6, 4'hc, 0, 0, 0);
      chk("sens_byp_div", 4'h2, sens_byp_div);
      chk("oos_byp_div", 4'h4, oos_byp_div);
      chk("sens_byp_annc", 1, sens_byp_annc);
      chk("oos_byp_annc", 1, oos_byp_annc);
      chk("maint_alarm", 1, maint_alarm);
      rchk(12'h008, 32'h42);
      @(posedge pclk) other_trip <= 4'hf;
      go(2);
      chk("div_trip_out", 4'hb, div_trip_out);
      sw(RN, 0, 4'h6, 4'hc, 0, 0, 4'h4);
      chk("div_trip_out", 4'hf, div_trip_out);
      @(posedge pclk) other_trip <= 4'h0;
      sw(RN, 0, 0, 0, 0, 0, 0);
      chk("maint_alarm", 0, maint_alarm);
      clr();
   endtask : t_maint
   task t_sd;
      sw(SD, 0, 0, 0, 0, 0, 0);
      chk("div_trip_out", 4'hf, div_trip_out);
      chk("man_trip_out", 3, man_trip_out);
      apb(1'b0, 12'h000, 32'h0);
      chk("sd state", 32'h4, d & 32'hf);
      go(25);
      apb(1'b0, 12'h000, 32'h0);
      chk("sd state", 32'hc, d & 32'hf);
      clr();
      sw(RN, 0, 0, 0, 0, 0, 0);
   endtask : t_sd
   task t_man;
      sw(RN, 0, 0, 0, 0, 2'h1, 0);
      chk("man_trip_out", 1, man_trip_out);
      chk("div_trip_out", 0, div_trip_out);
      sw(RN, 0, 0, 0, 0, 0, 0);
      clr();
   endtask : t_man

   // ==========================================================
   // verdict and main sequence
   task results;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {chg_low_trip, isolation_valve_trip, startup_range_monitor_trip} = '0;
      {flux_monitor_nc_trip, other_trip, srm_rod_block_in} = '0;
      go(8);
      presetn <= 1'b1;
      go(4);
      t_regs();
      t_chg();
      t_iso();
      t_srm();
      t_maint();
      t_sd();
      t_man();
      results();
   end
endmodule : ptbi_tb_top
